// [rtl/dcr_top.sv]
`timescale 1ns/1ps
`include "dcr_defs.svh"
module dcr_top (
    // Core clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // APB slave
    input wire dcr_pkg::dcr_apb_req_t i_apb,
    output dcr_pkg::dcr_apb_rsp_t o_apb,
    // Link side, on link clock
    input wire logic i_link_clk,
    input wire logic i_lk_push,
    input wire logic [31:0] i_lk_word,
    input wire logic i_lk_marker,
    input wire logic i_lk_restart,
    input wire logic i_lk_halt,
    input wire logic i_lk_comm_take,
    output logic o_lk_debug_acknowledge_flag,
    output logic o_lk_memory_request_low_flag,
    output logic [31:0] o_lk_comm_data,
    output logic o_lk_comm_valid,
    // Core status
    output logic o_running,
    output logic [31:0] o_pc
);
    dcr_pkg::dcr_core_t c_r;
    dcr_pkg::dcr_core_t c_nxt;
    dcr_pkg::dcr_link_t l_r;
    dcr_pkg::dcr_link_t l_nxt;

    logic push_ev;
    logic rst_ev;
    logic halt_ev;
    logic take_ev;
    logic apb_acc;
    logic apb_wr;
    logic is_stm;
    logic is_br;
    logic [31:0] br_ofs;
    logic [4:0] reg_cnt;

    assign push_ev = c_r.push_s[2] ^ c_r.push_s[1];
    assign rst_ev = c_r.rst_s[2] ^ c_r.rst_s[1];
    assign halt_ev = c_r.halt_s[2] ^ c_r.halt_s[1];
    assign take_ev = c_r.take_s[2] ^ c_r.take_s[1];
    assign apb_acc = i_apb.psel && i_apb.penable && !c_r.apb.pready;
    assign apb_wr = apb_acc && i_apb.pwrite;
    // Word is stable: host pushes at most once per link clock
    assign is_stm = (l_r.word & `DCR_STM_MASK) == `DCR_STM_CODE;
    assign is_br = l_r.word[`DCR_BR_MSB:`DCR_BR_LSB] == `DCR_BR_CODE;
    assign br_ofs = {{6{l_r.word[`DCR_BR_OFS_MSB]}}, l_r.word[`DCR_BR_OFS_MSB:0], 2'b00};

    always_comb begin
        reg_cnt = 5'h00;
        for (int i = 0; i < 16; i++) begin
            reg_cnt = reg_cnt + {4'h0, l_r.word[i]};
        end
    end

    always_comb begin
        c_nxt = c_r;
        c_nxt.push_s = {c_r.push_s[1:0], l_r.push_t};
        c_nxt.rst_s = {c_r.rst_s[1:0], l_r.rst_t};
        c_nxt.halt_s = {c_r.halt_s[1:0], l_r.halt_t};
        c_nxt.take_s = {c_r.take_s[1:0], l_r.take_t};
        c_nxt.apb.pready = apb_acc;
        c_nxt.apb.pslverr = 1'b0;
        c_nxt.apb.prdata = `DCR_ZERO32;

        if (push_ev && c_r.state == dcr_pkg::DCR_HALTED) begin
            // Marker on previous instruction selects system speed
            if (c_r.prev_marker && is_stm) begin
                c_nxt.arm = dcr_pkg::DCR_ARM_STM;
                c_nxt.stm_cnt = reg_cnt;
            end else if (c_r.prev_marker && is_br) begin
                c_nxt.arm = dcr_pkg::DCR_ARM_BR;
                c_nxt.pc = c_r.pc + `DCR_PC_AHEAD + br_ofs;
            end else begin
                c_nxt.arm = dcr_pkg::DCR_ARM_NONE;
            end
            c_nxt.prev_marker = l_r.marker;
        end

        case (c_r.state)
            dcr_pkg::DCR_HALTED: begin
                if (rst_ev && c_r.arm == dcr_pkg::DCR_ARM_STM) begin
                    c_nxt.state = dcr_pkg::DCR_SYS_STM;
                    c_nxt.arm = dcr_pkg::DCR_ARM_NONE;
                end else if (rst_ev && c_r.arm == dcr_pkg::DCR_ARM_BR) begin
                    c_nxt.state = dcr_pkg::DCR_RUN;
                    c_nxt.arm = dcr_pkg::DCR_ARM_NONE;
                    c_nxt.prev_marker = 1'b0;
                end
            end
            dcr_pkg::DCR_SYS_STM: begin
                if (c_r.stm_cnt == 5'h00) begin
                    c_nxt.state = dcr_pkg::DCR_HALTED;
                end else begin
                    c_nxt.stm_cnt = c_r.stm_cnt - 5'h01;
                end
            end
            dcr_pkg::DCR_RUN: begin
                c_nxt.pc = c_r.pc + `DCR_PC_STEP;
                if (halt_ev || (apb_wr && i_apb.paddr == `DCR_ADDR_CTRL &&
                                i_apb.pwdata[`DCR_CTRL_HALT_BIT])) begin
                    c_nxt.state = dcr_pkg::DCR_HALTED;
                end
            end
            default: c_nxt.state = dcr_pkg::DCR_HALTED;
        endcase

        // Host take clears, program write sets only when empty; a write while full is dropped, so clear wins
        if (take_ev) begin
            c_nxt.comm_full = 1'b0;
        end
        if (apb_acc) begin
            case (i_apb.paddr)
                `DCR_ADDR_IDENT: begin
                    c_nxt.apb.prdata = `DCR_IDENT_VALUE;
                    c_nxt.apb.pslverr = i_apb.pwrite;
                end
                `DCR_ADDR_COMM: begin
                    c_nxt.apb.prdata = c_r.comm;
                    if (i_apb.pwrite && !c_r.comm_full) begin
                        c_nxt.comm = i_apb.pwdata;
                        c_nxt.comm_full = 1'b1;
                        c_nxt.word_t = !c_r.word_t;
                    end
                end
                `DCR_ADDR_STATUS: begin
                    c_nxt.apb.prdata = {27'h0000000, c_r.comm_full, c_r.state, 1'b0,
                                        c_r.arm == dcr_pkg::DCR_ARM_NONE};
                end
                `DCR_ADDR_CTRL: c_nxt.apb.prdata = `DCR_ZERO32;
                default: c_nxt.apb.pslverr = 1'b1;
            endcase
        end
        // Single flops, so the link side syncs glitch-free levels
        c_nxt.running = c_nxt.state == dcr_pkg::DCR_RUN;
        c_nxt.halted = c_nxt.state == dcr_pkg::DCR_HALTED;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            c_r <= '0;
            c_r.pc <= `DCR_RESET_PC;
            c_r.halted <= 1'b1;
        end else begin
            c_r <= c_nxt;
        end
    end

    // Link domain: levels, toggles and held data words (word, marker, comm) cross
    always_comb begin
        l_nxt = l_r;
        l_nxt.ack_s = {l_r.ack_s[0], !c_r.running};
        l_nxt.mreq_s = {l_r.mreq_s[0], c_r.halted};
        l_nxt.word_s = {l_r.word_s[0], c_r.word_t};
        if (i_lk_push) begin
            l_nxt.word = i_lk_word;
            l_nxt.marker = i_lk_marker;
            l_nxt.push_t = !l_r.push_t;
        end
        if (i_lk_restart) begin
            l_nxt.rst_t = !l_r.rst_t;
        end
        if (i_lk_halt) begin
            l_nxt.halt_t = !l_r.halt_t;
        end
        // Toggle compare, so a taken word is never shown twice
        l_nxt.comm_valid = l_r.word_s[1] != l_r.seen_t;
        // Comm word held until taken, so safe to sample here
        if (l_nxt.comm_valid && !l_r.comm_valid) begin
            l_nxt.comm_out = c_r.comm;
        end
        if (l_r.comm_valid && i_lk_comm_take) begin
            l_nxt.take_t = !l_r.take_t;
            l_nxt.seen_t = l_r.word_s[1];
            l_nxt.comm_valid = 1'b0;
        end
    end

    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    assign o_apb = c_r.apb;
    assign o_lk_debug_acknowledge_flag = l_r.ack_s[1];
    assign o_lk_memory_request_low_flag = l_r.mreq_s[1];
    assign o_lk_comm_data = l_r.comm_out;
    assign o_lk_comm_valid = l_r.comm_valid;
    assign o_running = c_r.running;
    assign o_pc = c_r.pc;

    sequence s_stm_start;
        c_r.state == dcr_pkg::DCR_HALTED && rst_ev && c_r.arm == dcr_pkg::DCR_ARM_STM;
    endsequence

    sequence s_br_start;
        c_r.state == dcr_pkg::DCR_HALTED && rst_ev && c_r.arm == dcr_pkg::DCR_ARM_BR;
    endsequence

    property p_stm_back_halted;
        @(posedge i_clock) disable iff (i_rst)
        s_stm_start |=> c_r.state == dcr_pkg::DCR_SYS_STM ##[1:17] c_r.state == dcr_pkg::DCR_HALTED;
    endproperty
    a_stm_back_halted: assert property (p_stm_back_halted) else $error("store-multiple did not halt");

    property p_br_runs;
        @(posedge i_clock) disable iff (i_rst)
        s_br_start |=> c_r.state == dcr_pkg::DCR_RUN && c_r.pc == $past(c_r.pc);
    endproperty
    a_br_runs: assert property (p_br_runs) else $error("branch restart did not run");

    property p_run_stays;
        @(posedge i_clock) disable iff (i_rst)
        c_r.state == dcr_pkg::DCR_RUN && !halt_ev && !apb_wr |=> c_r.state == dcr_pkg::DCR_RUN;
    endproperty
    a_run_stays: assert property (p_run_stays) else $error("core left run unasked");

    property p_comm_set;
        @(posedge i_clock) disable iff (i_rst)
        apb_wr && i_apb.paddr == `DCR_ADDR_COMM && !c_r.comm_full |=> c_r.comm_full && c_r.comm == $past(i_apb.pwdata);
    endproperty
    a_comm_set: assert property (p_comm_set) else $error("comm write lost");
endmodule : dcr_top

// [rtl/dcr_defs.svh]
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH
// Overview of operation
// - A store-multiple run at system speed ends with the core halted again.
// - Branch after a speed-marked instruction resyncs to system clock, stays running.
// - A branch to the download address restarts the core into that program.
// - Running program returns flash codes to host through the communications register.

// APB register byte addresses
`define DCR_ADDR_IDENT 32'hFFF00000
`define DCR_ADDR_COMM 32'hFFF00010
`define DCR_ADDR_STATUS 32'hFFF00014
`define DCR_ADDR_CTRL 32'hFFF00018
// Arbitrary neutral identity value
`define DCR_IDENT_VALUE 32'h0000_0A5C
`define DCR_CTRL_HALT_BIT 0
// Instruction classification
`define DCR_STM_MASK 32'hFFFF0000
`define DCR_STM_CODE 32'hE88E0000
`define DCR_BR_MSB 27
`define DCR_BR_LSB 25
`define DCR_BR_CODE 3'h5
`define DCR_BR_OFS_MSB 23
`define DCR_PC_AHEAD 32'h0000_0008
`define DCR_PC_STEP 32'h0000_0004
`define DCR_RESET_PC 32'h0000_0000
`define DCR_ZERO32 32'h0000_0000
`endif

// [rtl/dcr_pkg.sv]
package dcr_pkg;
    typedef enum logic [1:0] {
        DCR_HALTED = 2'b00,
        DCR_SYS_STM = 2'b01,
        DCR_RUN = 2'b10
    } dcr_state_t;

    typedef enum logic [1:0] {
        DCR_ARM_NONE = 2'b00,
        DCR_ARM_STM = 2'b01,
        DCR_ARM_BR = 2'b10
    } dcr_arm_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } dcr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dcr_apb_rsp_t;

    // Core clock domain
    typedef struct packed {
        dcr_apb_rsp_t apb;
        dcr_state_t state;
        dcr_arm_t arm;
        logic prev_marker;
        logic [4:0] stm_cnt;
        logic [31:0] pc;
        logic [31:0] comm;
        logic comm_full;
        logic running;
        logic halted;
        logic word_t;
        logic [2:0] push_s;
        logic [2:0] rst_s;
        logic [2:0] halt_s;
        logic [2:0] take_s;
    } dcr_core_t;

    // Link clock domain
    typedef struct packed {
        logic [31:0] word;
        logic marker;
        logic push_t;
        logic rst_t;
        logic halt_t;
        logic take_t;
        logic [1:0] ack_s;
        logic [1:0] mreq_s;
        logic [1:0] word_s;
        logic seen_t;
        logic [31:0] comm_out;
        logic comm_valid;
    } dcr_link_t;
endpackage : dcr_pkg

// [tb/dcr_host_model.sv]
`timescale 1ns/1ps
module dcr_host_model (
    // Link clock
    input wire logic i_link_clk,
    // Link requests
    output logic o_push,
    output logic [31:0] o_word,
    output logic o_marker,
    output logic o_restart,
    output logic o_halt,
    output logic o_take
);
    initial begin
        o_push = 1'b0;
        o_word = 32'h0000_0000;
        o_marker = 1'b0;
        o_restart = 1'b0;
        o_halt = 1'b0;
        o_take = 1'b0;
    end

    // Word lines show the inverse once released, so stale data never looks valid
    task send(input logic [31:0] w, input logic m);
        @(posedge i_link_clk);
        o_push <= 1'b1;
        o_word <= w;
        o_marker <= m;
        @(posedge i_link_clk);
        o_push <= 1'b0;
        o_word <= ~w;
        o_marker <= ~m;
    endtask : send

    // Kind 0 resume, 1 halt, 2 take comm word
    task pulse(input int kind);
        @(posedge i_link_clk);
        o_restart <= (kind == 0);
        o_halt <= (kind == 1);
        o_take <= (kind == 2);
        @(posedge i_link_clk);
        o_restart <= 1'b0;
        o_halt <= 1'b0;
        o_take <= 1'b0;
    endtask : pulse
endmodule : dcr_host_model

// [tb/debug_core_restart_upload_seq_tb.sv]
`timescale 1ns/1ps
`include "dcr_defs.svh"
module debug_core_restart_upload_seq_tb;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_link_clk = 1'b0;
    dcr_pkg::dcr_apb_req_t apb = '0;
    dcr_pkg::dcr_apb_rsp_t rsp;
    logic push, mark, rst_l, halt_l, take, ack, mreq, cval, run;
    logic [31:0] word, cdat, pc, rd;
    logic err;
    int n_fail = 0;
    int cmp_count = 0;

    initial forever #10 i_clock = ~i_clock;
    // Link clock offset so its edges never line up with the core clock
    initial begin
        #7;
        forever #80 i_link_clk = ~i_link_clk;
    end

    dcr_host_model u_host (.i_link_clk(i_link_clk), .o_push(push), .o_word(word), .o_marker(mark),
        .o_restart(rst_l), .o_halt(halt_l), .o_take(take));

    dcr_top u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_apb(apb), .o_apb(rsp), .i_link_clk(i_link_clk),
        .i_lk_push(push), .i_lk_word(word), .i_lk_marker(mark), .i_lk_restart(rst_l),
        .i_lk_halt(halt_l), .i_lk_comm_take(take), .o_lk_debug_acknowledge_flag(ack),
        .o_lk_memory_request_low_flag(mreq), .o_lk_comm_data(cdat), .o_lk_comm_valid(cval),
        .o_running(run), .o_pc(pc));

    task conclude;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    // Held until pready is sampled high at a rising edge; answer taken at that edge
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge i_clock);
        apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge i_clock);
        apb.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge i_clock);
            if (rsp.pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            conclude();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask : xfer

    // Sel 0 both flags, 1 running, 2 comm valid
    task wait_for(input int sel, input logic v);
        int i;
        for (i = 0; i < 300; i++) begin
            @(negedge i_clock);
            if (sel == 0 && ack === v && mreq === v) break;
            if (sel == 1 && run === v) break;
            if (sel == 2 && cval === v) break;
        end
        if (i == 300) begin
            n_fail++;
            conclude();
        end
    endtask : wait_for

    initial begin
        // Asynchronous in both domains, so no link edge is needed
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        wait_for(0, 1'b1);
        xfer(1'b0, `DCR_ADDR_IDENT, 32'h0);
        chk(rd, `DCR_IDENT_VALUE);
        xfer(1'b1, `DCR_ADDR_IDENT, 32'h1111_2222);
        chk({31'h0, err}, 32'h1);
        xfer(1'b0, 32'hFFF0_0020, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        xfer(1'b0, `DCR_ADDR_STATUS, 32'h0);
        chk(rd & 32'h0000_001C, 32'h0);
        u_host.pulse(0);
        repeat (20) @(posedge i_clock);
        chk({31'h0, run}, 32'h0);
        u_host.send(32'hE89E_8000, 1'b0);
        u_host.send(32'hE1A0_0000, 1'b1);
        u_host.send(32'hEAFF_FFFE, 1'b0);
        u_host.pulse(0);
        wait_for(1, 1'b1);
        wait_for(0, 1'b0);
        xfer(1'b1, `DCR_ADDR_COMM, 32'h1234_ABCD);
        xfer(1'b0, `DCR_ADDR_STATUS, 32'h0);
        chk(rd & 32'h0000_001C, 32'h0000_0018);
        wait_for(2, 1'b1);
        chk(cdat, 32'h1234_ABCD);
        u_host.pulse(2);
        wait_for(2, 1'b0);
        u_host.pulse(1);
        wait_for(0, 1'b1);
        chk({31'h0, run}, 32'h0);
        for (int k = 0; k < 3; k++) begin
            u_host.send(32'hE89E_8000, 1'b0);
            u_host.send(32'hE1A0_0000, 1'b1);
            u_host.send(`DCR_STM_CODE | ((32'h2 << k) - 32'h1), 1'b0);
            // Let the push cross before checking that the store is armed
            repeat (5) @(posedge i_clock);
            xfer(1'b0, `DCR_ADDR_STATUS, 32'h0);
            chk(rd & 32'h0000_001D, 32'h0);
            u_host.pulse(0);
            repeat (40) @(posedge i_clock);
            wait_for(0, 1'b1);
            xfer(1'b0, `DCR_ADDR_STATUS, 32'h0);
            chk({run, 26'h0, rd[4:0]}, 32'h0000_0001);
        end
        conclude();
    end
endmodule : debug_core_restart_upload_seq_tb
